// file: core/servo_control_word_decoder.sv
`timescale 1ns/1ns
// Operation
// - Second word bit 8 commands endstop traverse
// - Second word bits 12-15 carry sign-of-life
// - Config bit 0 low ignores bypass bit
// - Telegram 105 ignores first word bits 4-6
// - Bit 0 low ramps down, then ready
// - Bit 1 low suppresses pulses, inhibits on
// - Bit 2 low fast-stop ramp, then inhibit
// - Bit 3 enables operation, low suppresses pulses
// - Speed bit 4 low zeroes ramp output
// - Speed bit 5 low freezes ramp output
// - Speed bit 6 low zeroes ramp input
// - Bit 7 set acknowledges pending faults
// - Bit 10 must be high for control
// - Telegrams 102/105: ramp active, brake open
// - Telegrams 102/105: ramp bypass, integrator inhibit
// - Positioning bit 4 low rejects traversing task
// - Positioning bit 5 low intermediate stop
// - Positioning bits 8, 9 select jog sources
// - Block select bits 0-5 give block number
module servo_control_word_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Cyclic receive words, taken on wordStrobe
   input wire logic wordStrobe,
   input wire logic [servo_cw_pkg::WORD_W-1:0] commandWordOne,
   input wire logic [servo_cw_pkg::WORD_W-1:0] commandWordTwo,
   input wire logic [servo_cw_pkg::WORD_W-1:0] blockSelectWord,
   input wire logic [servo_cw_pkg::TGM_W-1:0] telegramSel,
   input wire logic [servo_cw_pkg::WORD_W-1:0] rampBypassConfigParam,
   // Feedback from the drive
   input wire logic speedAtZero,
   input wire logic faultPresent,
   // Power stage and stop commands
   output logic pulseEnable,
   output logic switchOnInhibit,
   output logic rampStopActive,
   output logic coastStopActive,
   output logic fastStopActive,
   output logic useFastStopRampParam,
   output logic operationEnabled,
   // Ramp generator and speed loop
   output logic rampOutZero,
   output logic rampFreeze,
   output logic rampInZero,
   output logic rampActive,
   output logic rampBypass,
   output logic integratorInhibit,
   output logic brakeOpen,
   output logic endstopTraverse,
   // Positioning
   output logic rejectTask,
   output logic intermediateStop,
   output logic jogSourceOne,
   output logic jogSourceTwo,
   output logic referencingStart,
   output logic [servo_cw_pkg::BLOCK_W-1:0] blockNumber,
   output logic manualDataInput,
   // Control and supervision
   output logic plcControl,
   output logic faultAck,
   output logic [servo_cw_pkg::SOL_W-1:0] signOfLife,
   output logic signOfLifeError
);
   import servo_cw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Telegram classification
   function automatic logic isSpeedTgm(input logic [TGM_W-1:0] t);
      isSpeedTgm = (t == TGM_1) || (t == TGM_2) || (t == TGM_3) ||
         (t == TGM_5) || (t == TGM_102) || (t == TGM_105);
   endfunction

   function automatic logic isPosTgm(input logic [TGM_W-1:0] t);
      isPosTgm = (t == TGM_7) || (t == TGM_9) || (t == TGM_110) ||
         (t == TGM_111);
   endfunction

   function automatic logic isExtTgm(input logic [TGM_W-1:0] t);
      isExtTgm = (t == TGM_102) || (t == TGM_105);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   logic rstMeta_reg;
   logic rstSync_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Captured words
   logic [WORD_W-1:0] wordOne_reg;
   logic [WORD_W-1:0] wordTwo_reg;
   logic [WORD_W-1:0] blockSel_reg;
   logic [TGM_W-1:0] tgm_reg;
   logic bypassCfg_reg;
   logic plc_reg;
   logic ackPrev_reg;
   logic takeWords;

   // Words are only honoured while the controller claims control
   assign takeWords = wordStrobe && commandWordOne[W1_PLC];

   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         wordOne_reg <= WORD_RST;
         wordTwo_reg <= WORD_RST;
         blockSel_reg <= WORD_RST;
         tgm_reg <= TGM_1;
         bypassCfg_reg <= 1'b0;
      end else if (takeWords) begin
         wordOne_reg <= commandWordOne;
         wordTwo_reg <= commandWordTwo;
         blockSel_reg <= blockSelectWord;
         tgm_reg <= telegramSel;
         bypassCfg_reg <= rampBypassConfigParam[CFG_BYPASS_BIT];
      end
   end

   // Control flag follows every word, so dropping bit 10 is seen
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         plc_reg <= 1'b0;
      end else if (wordStrobe) begin
         plc_reg <= commandWordOne[W1_PLC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded stop requests; loss of control counts as coast stop
   logic onReq;
   logic coastReq;
   logic fastReq;
   logic enaOpReq;

   assign onReq = plc_reg && wordOne_reg[W1_ON];
   assign coastReq = !plc_reg || !wordOne_reg[W1_NO_COAST];
   assign fastReq = !wordOne_reg[W1_NO_FAST];
   assign enaOpReq = wordOne_reg[W1_ENA_OP];

   ////////////////////////////////////////////////////////////////////////////
   // Drive power state machine
   drive_state_t state_reg;
   drive_state_t state_next;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_INHIBIT: begin
            // Inhibit lifts only once ON is dropped
            if (!coastReq && !fastReq && !onReq) begin
               state_next = ST_READY;
            end
         end
         ST_READY: begin
            if (coastReq || fastReq) begin
               state_next = ST_INHIBIT;
            end else if (onReq && enaOpReq && !faultPresent) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (coastReq) begin
               state_next = ST_INHIBIT;
            end else if (!enaOpReq) begin
               state_next = ST_READY;
            end else if (fastReq) begin
               state_next = ST_FAST_STOP;
            end else if (!onReq) begin
               state_next = ST_RAMP_STOP;
            end
         end
         ST_RAMP_STOP: begin
            if (coastReq) begin
               state_next = ST_INHIBIT;
            end else if (!enaOpReq) begin
               state_next = ST_READY;
            end else if (fastReq) begin
               state_next = ST_FAST_STOP;
            end else if (speedAtZero) begin
               state_next = ST_READY;
            end
         end
         ST_FAST_STOP: begin
            // Suppressing pulses still ends in switch-on inhibit
            if (coastReq || !enaOpReq || speedAtZero) begin
               state_next = ST_INHIBIT;
            end
         end
         default: begin
            state_next = ST_INHIBIT;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         state_reg <= ST_INHIBIT;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power stage outputs, registered from the next state; coastStopActive registered from coastReq
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         pulseEnable <= 1'b0;
         switchOnInhibit <= 1'b1;
         rampStopActive <= 1'b0;
         fastStopActive <= 1'b0;
         useFastStopRampParam <= 1'b0;
         operationEnabled <= 1'b0;
         coastStopActive <= 1'b0;
      end else begin
         pulseEnable <= (state_next == ST_RUN) ||
            (state_next == ST_RAMP_STOP) ||
            (state_next == ST_FAST_STOP);
         switchOnInhibit <= (state_next == ST_INHIBIT);
         rampStopActive <= (state_next == ST_RAMP_STOP);
         fastStopActive <= (state_next == ST_FAST_STOP);
         useFastStopRampParam <= (state_next == ST_FAST_STOP);
         operationEnabled <= (state_next == ST_RUN);
         coastStopActive <= coastReq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ramp generator and speed loop controls
   logic speedTgm;
   logic extTgm;
   logic posTgm;
   logic gate456;

   assign speedTgm = isSpeedTgm(tgm_reg);
   assign extTgm = isExtTgm(tgm_reg);
   assign posTgm = isPosTgm(tgm_reg);
   // Telegram 105 leaves bits 4 to 6 without effect
   assign gate456 = speedTgm && (tgm_reg != TGM_105);

   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         rampOutZero <= 1'b1;
         rampFreeze <= 1'b0;
         rampInZero <= 1'b1;
         rampActive <= 1'b0;
         rampBypass <= 1'b0;
         integratorInhibit <= 1'b0;
         brakeOpen <= 1'b0;
         endstopTraverse <= 1'b0;
      end else begin
         rampOutZero <= gate456 && !wordOne_reg[W1_BIT4];
         rampFreeze <= gate456 && !wordOne_reg[W1_BIT5];
         rampInZero <= gate456 && !wordOne_reg[W1_BIT6];
         rampActive <= extTgm && wordOne_reg[W1_BIT11];
         brakeOpen <= extTgm && wordOne_reg[W1_BRAKE];
         // Bypass needs both the telegram and the config bit
         rampBypass <= extTgm && bypassCfg_reg &&
            wordTwo_reg[W2_BYPASS];
         integratorInhibit <= extTgm && wordTwo_reg[W2_INT_INH];
         endstopTraverse <= speedTgm && wordTwo_reg[W2_ENDSTOP];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Positioning controls; only named bits are decoded
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         rejectTask <= 1'b0;
         intermediateStop <= 1'b0;
         jogSourceOne <= 1'b0;
         jogSourceTwo <= 1'b0;
         referencingStart <= 1'b0;
         blockNumber <= '0;
         manualDataInput <= 1'b0;
      end else begin
         rejectTask <= posTgm && !wordOne_reg[W1_BIT4];
         intermediateStop <= posTgm && !wordOne_reg[W1_BIT5];
         jogSourceOne <= posTgm && wordOne_reg[W1_JOG1];
         jogSourceTwo <= posTgm && wordOne_reg[W1_JOG2];
         referencingStart <= posTgm && wordOne_reg[W1_BIT11];
         if (posTgm && (tgm_reg != TGM_111)) begin
            blockNumber <= blockSel_reg[BS_MSB:BS_LSB];
            manualDataInput <= blockSel_reg[BS_MANUAL];
         end else begin
            blockNumber <= '0;
            manualDataInput <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault acknowledge: one pulse per rising edge of bit 7
   logic ackEdge;

   assign ackEdge = takeWords && commandWordOne[W1_ACK] && !ackPrev_reg;

   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         ackPrev_reg <= 1'b0;
         faultAck <= 1'b0;
      end else begin
         if (takeWords) begin
            ackPrev_reg <= commandWordOne[W1_ACK];
         end
         faultAck <= ackEdge;
      end
   end

   assign plcControl = plc_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sign-of-life monitor: each new value must step by one
   logic solSeen_reg;
   logic [SOL_W-1:0] solNew;
   logic solBad;

   assign solNew = commandWordTwo[W2_SOL_MSB:W2_SOL_LSB];
   assign solBad = takeWords && solSeen_reg &&
      (solNew != signOfLife + SOL_STEP);

   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         signOfLife <= SOL_RST;
         solSeen_reg <= 1'b0;
      end else if (takeWords) begin
         signOfLife <= solNew;
         solSeen_reg <= 1'b1;
      end
   end

   // Sticky error, a fresh miss wins over an acknowledge
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         signOfLifeError <= 1'b0;
      end else if (solBad) begin
         signOfLifeError <= 1'b1;
      end else if (ackEdge) begin
         signOfLifeError <= 1'b0;
      end
   end

endmodule

// file: core/servo_cw_pkg.sv
package servo_cw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Word and field widths
   localparam int WORD_W = 16;
   localparam int SOL_W = 4;
   localparam int BLOCK_W = 6;
   localparam int TGM_W = 7;

   ////////////////////////////////////////////////////////////////////////////
   // First command word, common bits
   localparam int W1_ON = 0;
   localparam int W1_NO_COAST = 1;
   localparam int W1_NO_FAST = 2;
   localparam int W1_ENA_OP = 3;
   localparam int W1_BIT4 = 4;
   localparam int W1_BIT5 = 5;
   localparam int W1_BIT6 = 6;
   localparam int W1_ACK = 7;
   localparam int W1_JOG1 = 8;
   localparam int W1_JOG2 = 9;
   localparam int W1_PLC = 10;
   localparam int W1_BIT11 = 11;
   localparam int W1_BRAKE = 12;

   ////////////////////////////////////////////////////////////////////////////
   // Second command word and block select word
   localparam int W2_BYPASS = 4;
   localparam int W2_INT_INH = 6;
   localparam int W2_ENDSTOP = 8;
   localparam int W2_SOL_LSB = 12;
   localparam int W2_SOL_MSB = 15;
   localparam int BS_LSB = 0;
   localparam int BS_MSB = 5;
   localparam int BS_MANUAL = 15;
   localparam int CFG_BYPASS_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Telegram numbers
   localparam logic [TGM_W-1:0] TGM_1 = 7'h01;
   localparam logic [TGM_W-1:0] TGM_2 = 7'h02;
   localparam logic [TGM_W-1:0] TGM_3 = 7'h03;
   localparam logic [TGM_W-1:0] TGM_5 = 7'h05;
   localparam logic [TGM_W-1:0] TGM_7 = 7'h07;
   localparam logic [TGM_W-1:0] TGM_9 = 7'h09;
   localparam logic [TGM_W-1:0] TGM_102 = 7'h66;
   localparam logic [TGM_W-1:0] TGM_105 = 7'h69;
   localparam logic [TGM_W-1:0] TGM_110 = 7'h6e;
   localparam logic [TGM_W-1:0] TGM_111 = 7'h6f;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [SOL_W-1:0] SOL_RST = 4'h0;
   localparam logic [SOL_W-1:0] SOL_STEP = 4'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Drive power state, Gray along the usual path
   typedef enum logic [2:0] {
      ST_INHIBIT = 3'b000,
      ST_READY = 3'b001,
      ST_RUN = 3'b011,
      ST_RAMP_STOP = 3'b010,
      ST_FAST_STOP = 3'b110
   } drive_state_t;

endpackage

// file: test/cw_decoder_props.sv
`timescale 1ns/1ns
module cw_decoder_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Words from the controller
   input wire logic wordStrobe,
   input wire logic [servo_cw_pkg::WORD_W-1:0] commandWordOne,
   input wire logic [servo_cw_pkg::WORD_W-1:0] commandWordTwo,
   input wire logic [servo_cw_pkg::WORD_W-1:0] blockSelectWord,
   input wire logic [servo_cw_pkg::TGM_W-1:0] telegramSel,
   input wire logic [servo_cw_pkg::WORD_W-1:0] rampBypassConfigParam,
   // Decoded outputs
   input wire logic pulseEnable,
   input wire logic switchOnInhibit,
   input wire logic fastStopActive,
   input wire logic useFastStopRampParam,
   input wire logic rampOutZero,
   input wire logic rampFreeze,
   input wire logic rampBypass,
   input wire logic brakeOpen,
   input wire logic endstopTraverse,
   input wire logic [servo_cw_pkg::BLOCK_W-1:0] blockNumber,
   input wire logic manualDataInput,
   input wire logic plcControl,
   input wire logic faultAck,
   input wire logic [servo_cw_pkg::SOL_W-1:0] signOfLife
);
   import servo_cw_pkg::*;
   logic take;
   // Accepted telegram; refused ones still update the control flag and power state
   assign take = wordStrobe && commandWordOne[W1_PLC];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Decode lands one edge after the strobe is taken
   inhibit_no_pulse_a: assert property (
      switchOnInhibit |-> !pulseEnable)
      else $error("pulses on while switch-on inhibited");
   fast_stop_ramp_a: assert property (
      fastStopActive |-> pulseEnable && useFastStopRampParam)
      else $error("fast stop without its ramp");
   gate_105_a: assert property (
      take && telegramSel == TGM_105 |=> ##1 !rampOutZero && !rampFreeze)
      else $error("ramp bits decoded for telegram 105");
   bypass_cfg_a: assert property (
      take && !rampBypassConfigParam[CFG_BYPASS_BIT] |=> ##1 !rampBypass)
      else $error("bypass set while config bit low");
   brake_endstop_a: assert property (
      take && telegramSel == TGM_102 |=> ##1
      brakeOpen == $past(commandWordOne[W1_BRAKE], 2) &&
      endstopTraverse == $past(commandWordTwo[W2_ENDSTOP], 2))
      else $error("brake or endstop decode wrong");
   sol_value_a: assert property (
      take |=> signOfLife == $past(commandWordTwo[W2_SOL_MSB:W2_SOL_LSB]))
      else $error("sign of life not taken");
   // Flag drops at once, inhibit one edge later; a new strobe cannot undo it
   control_loss_a: assert property (
      wordStrobe && !commandWordOne[W1_PLC] |=>
      !plcControl ##1 switchOnInhibit)
      else $error("control kept without control bit");
   // Acknowledge pulse is launched on the edge that takes the word
   ack_pulse_a: assert property (
      faultAck |-> $past(wordStrobe) && $past(commandWordOne[W1_ACK])
      ##1 !faultAck)
      else $error("fault acknowledge pulse wrong");
   block_num_a: assert property (
      take && telegramSel == TGM_7 |=> ##1
      blockNumber == $past(blockSelectWord[BS_MSB:BS_LSB], 2) &&
      manualDataInput == $past(blockSelectWord[BS_MANUAL], 2))
      else $error("block select decode wrong");
endmodule

// file: test/cw_master_model.sv
`timescale 1ns/1ns
module cw_master_model (
   // Bench requests
   input wire logic clk,
   input wire logic send,
   input wire logic badSol,
   input wire logic [servo_cw_pkg::WORD_W-1:0] w1In,
   input wire logic [servo_cw_pkg::WORD_W-1:0] w2In,
   input wire logic [servo_cw_pkg::WORD_W-1:0] bsIn,
   // Cyclic words toward the drive
   output logic wordStrobe,
   output logic [servo_cw_pkg::WORD_W-1:0] commandWordOne,
   output logic [servo_cw_pkg::WORD_W-1:0] commandWordTwo,
   output logic [servo_cw_pkg::WORD_W-1:0] blockSelectWord
);
   import servo_cw_pkg::*;
   logic [SOL_W-1:0] solReg;
   logic [SOL_W-1:0] solNow;
   // A commanded skip breaks the count on purpose
   assign solNow = solReg + {3'h0, badSol};
   // Known levels before the first telegram
   initial begin
      solReg = SOL_RST;
      wordStrobe = 1'b0;
      commandWordOne = WORD_RST;
      commandWordTwo = WORD_RST;
      blockSelectWord = WORD_RST;
   end
   ////////////////////////////////////////
   // Idle words are inverted so stale data never looks valid
   always @(negedge clk) begin
      wordStrobe <= send;
      if (send) begin
         commandWordOne <= w1In;
         commandWordTwo <= {solNow, w2In[11:0] & 12'h150};
         blockSelectWord <= bsIn & 16'h803F;
         solReg <= solNow + SOL_STEP;
      end else begin
         commandWordOne <= ~commandWordOne;
         commandWordTwo <= ~commandWordTwo;
         blockSelectWord <= ~blockSelectWord;
      end
   end
endmodule

// file: test/servo_control_word_decoder_tb_top.sv
`timescale 1ns/1ns
module servo_control_word_decoder_tb_top;
   import servo_cw_pkg::*;
   logic clk, rst_b, send, badSol, speedAtZero, faultPresent, wordStrobe;
   logic ackExp, ackLast, ackSeen;
   logic [WORD_W-1:0] w1In, w2In, bsIn, rampBypassConfigParam;
   logic [WORD_W-1:0] commandWordOne, commandWordTwo, blockSelectWord;
   logic [TGM_W-1:0] telegramSel;
   logic [SOL_W-1:0] solExp, solSent, signOfLife;
   logic [BLOCK_W-1:0] blockNumber;
   logic [23:0] decoded, expv;
   logic [3:0] pwr;
   logic pulseEnable, switchOnInhibit, rampStopActive, coastStopActive;
   logic fastStopActive, useFastStopRampParam, operationEnabled;
   logic rampOutZero, rampFreeze, rampInZero, rampActive, rampBypass;
   logic integratorInhibit, brakeOpen, endstopTraverse, rejectTask;
   logic intermediateStop, jogSourceOne, jogSourceTwo, referencingStart;
   logic manualDataInput, plcControl, faultAck, signOfLifeError;
   int miscompares, cmp_count;
   logic [TGM_W-1:0] tels[10] = '{TGM_1, TGM_2, TGM_3, TGM_5, TGM_7,
      TGM_9, TGM_102, TGM_105, TGM_110, TGM_111};
   // Power walk: word, then {speedAtZero, faultPresent, pulse, inhibit,
   // ramp stop, fast stop}
   logic [15:0] seqW[16] = '{16'h040E, 16'h040F, 16'h040B, 16'h040B,
      16'h040E, 16'h040F, 16'h040E, 16'h040E, 16'h040F, 16'h040D,
      16'h040E, 16'h040F, 16'h0407, 16'h040F, 16'h040F, 16'h000F};
   logic [5:0] seqX[16] = '{6'h00, 6'h08, 6'h09, 6'h24, 6'h00, 6'h08,
      6'h0A, 6'h20, 6'h08, 6'h04, 6'h00, 6'h08, 6'h00, 6'h10, 6'h08, 6'h04};

   servo_control_word_decoder DUT (.*);
   cw_master_model master (.*);

   assign pwr = {pulseEnable, switchOnInhibit, rampStopActive, fastStopActive};
   assign decoded = {rampOutZero, rampFreeze, rampInZero, rampActive,
      brakeOpen, rampBypass, integratorInhibit, endstopTraverse, rejectTask,
      intermediateStop, jogSourceOne, jogSourceTwo, referencingStart,
      blockNumber, manualDataInput, signOfLife};
   ////////////////////////////////////////
   // Expected decode of the words last handed to the controller model
   function automatic logic [23:0] dec();
      logic sp, g, ps, bk, ns;
      sp = telegramSel inside {TGM_1, TGM_2, TGM_3, TGM_5, TGM_102, TGM_105};
      g = telegramSel inside {TGM_102, TGM_105};
      ps = telegramSel inside {TGM_7, TGM_9, TGM_110, TGM_111};
      bk = telegramSel inside {TGM_7, TGM_9, TGM_110};
      ns = sp && telegramSel != TGM_105;
      return {ns & !w1In[4], ns & !w1In[5], ns & !w1In[6], g & w1In[11],
         g & w1In[12], g & rampBypassConfigParam[0] & w2In[4], g & w2In[6],
         sp & w2In[8], ps & !w1In[4], ps & !w1In[5], ps & w1In[8],
         ps & w1In[9], ps & w1In[11], bk ? bsIn[5:0] : 6'h00,
         bk & bsIn[15], solSent};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One telegram; decode has settled by the return
   task automatic put(input logic [15:0] a, b, c);
      @(negedge clk);
      w1In = a;
      w2In = b;
      bsIn = c;
      send <= 1'b1;
      @(negedge clk);
      send <= 1'b0;
      solSent = solExp + {3'h0, badSol};
      solExp = solSent + 4'h1;
      if (a[W1_PLC]) begin
         ackExp = a[W1_ACK] & !ackLast;
         ackLast = a[W1_ACK];
      end
      // Acknowledge stands only in the cycle after the taking edge
      @(negedge clk);
      ackSeen = faultAck;
      @(negedge clk);
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Run is under two hundred cycles; this leaves a wide margin
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
   ////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(50840));
      {rst_b, send, badSol, speedAtZero, faultPresent, ackLast} = '0;
      {w1In, w2In, bsIn, rampBypassConfigParam, solExp} = '0;
      telegramSel = TGM_1;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      check("reset", pwr, 4'h4);
      $display("reset test done");
      for (int i = 0; i < 16; i++) begin
         {speedAtZero, faultPresent} = seqX[i][5:4];
         put(seqW[i], 16'h0000, 16'h0000);
         check("power", pwr, seqX[i][3:0]);
         check("plc", plcControl, seqW[i][W1_PLC]);
         check("coast", coastStopActive,
            !seqW[i][W1_PLC] || !seqW[i][W1_NO_COAST]);
         check("run", operationEnabled, seqX[i][3:0] == 4'h8);
         check("fastramp", useFastStopRampParam, seqX[i][0]);
      end
      $display("power test done");
      for (int i = 0; i < 20; i++) begin
         telegramSel = tels[i % 10];
         rampBypassConfigParam = 16'($urandom);
         put(16'($urandom) | 16'h0400, 16'($urandom), 16'($urandom));
         expv = dec();
         check("ramp", decoded[23:21], expv[23:21]);
         check("ext", decoded[20:16], expv[20:16]);
         check("pos", decoded[15:11], expv[15:11]);
         check("block", decoded[10:4], expv[10:4]);
         check("life", decoded[3:0], expv[3:0]);
         check("ack", ackSeen, ackExp);
      end
      $display("decode test done");
      put(16'h0400, 16'h0000, 16'h0000);
      put(16'h0480, 16'h0000, 16'h0000);
      check("ack", ackSeen, 1);
      @(negedge clk);
      check("lifeerr", signOfLifeError, 0);
      badSol = 1'b1;
      put(16'h0400, 16'h0000, 16'h0000);
      badSol = 1'b0;
      check("lifeerr", signOfLifeError, 1);
      $display("sign of life test done");
      close_out();
   end
endmodule

bind servo_control_word_decoder cw_decoder_props checker_i (.*);
